// ===== swsbs_dev.sv
`timescale 1ns/1ps
// How it works
// R01 - three low slots start a new frame
// R02 - master sends eight bits after start
// R03 - command then address, each LSB first
// R04 - command bits drive inhibit, direction, energize
// R05 - sync rising edge latches command bits
// R06 - latch only on fully validated push
// R07 - slave returns three status bits, MSB first
// R08 - status code table, never zero
// R09 - master needs good code plus end-of-frame
// R10 - slave sends end-of-frame from slot clock
// R11 - ones with silent end-of-frame means failure
// R12 - two samples per half slot must match
// R13 - both sides share a 25 us slot
// R14 - slot is sixteen oscillator periods
// R15 - oscillator nominal 640 kHz
// R16 - bit halves must be complementary
// R17 - nine low slots disable outputs
// R18 - act only on matching address
// R19 - on error, no latch, report 111
module swsbs_dev #(
  parameter int SLOT_CYC = swsbs_pkg::SLOT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  swsbs_link_if.dev bus,
  input wire logic [2:0] my_address,
  input wire logic fault_no_bemf,
  input wire logic over_temp,
  input wire logic programming,
  output logic bridge_one_inhibit,
  output logic bridge_one_direction,
  output logic energize,
  output logic bridge_two_direction,
  output logic bridge_two_inhibit,
  output logic outputs_disabled,
  output logic frame_latched,
  output logic rx_noise_error,
  output logic rx_biphase_error,
  output logic rx_field_error
);
  // slot timing derived from the oscillator rate [R13] [R14] [R15]
  localparam logic [15:0] SLOT_W = 16'(SLOT_CYC);
  localparam logic [15:0] SLOT_M1 = 16'(SLOT_CYC - 1);
  localparam logic [15:0] HALF = 16'(SLOT_CYC / 2);
  localparam logic [15:0] Q1 = 16'(SLOT_CYC / 8);
  localparam logic [15:0] Q3 = 16'(3 * SLOT_CYC / 8);
  localparam logic [15:0] Q5 = 16'(5 * SLOT_CYC / 8);
  localparam logic [15:0] Q7 = 16'(7 * SLOT_CYC / 8);
  localparam logic [15:0] SYNC_TMO = 16'(2 * SLOT_CYC);
  localparam logic [19:0] START_C =
    20'(swsbs_pkg::START_SLOTS * SLOT_CYC);
  localparam logic [19:0] KILL_C =
    20'(swsbs_pkg::KILL_SLOTS * SLOT_CYC);
  localparam logic [3:0] LAST_BIT = 4'(swsbs_pkg::PUSH_BITS - 1);
  localparam logic [3:0] LAST_STAT = 4'(swsbs_pkg::STAT_BITS - 1);
  localparam logic [3:0] LAST_EOF = 4'(swsbs_pkg::EOF_SLOTS - 1);

  typedef struct packed {
    logic [2:0] syn;
    logic lvl;
    swsbs_pkg::swsbs_dev_st_t st;
    logic [19:0] low_cnt;
    logic [15:0] ph;
    logic [3:0] bit_n;
    logic smp_a;
    logic smp_b;
    logic smp_c;
    logic [7:0] sh;
    logic err_noise;
    logic err_bip;
    logic err_field;
    logic [2:0] stat;
    logic eof_en;
    logic drive_low;
    logic [4:0] cmd;
    logic off;
    logic latch_pulse;
  } swsbs_dev_state_t;

  swsbs_dev_state_t q;
  swsbs_dev_state_t d;
  logic lvl_n;
  logic rise;
  logic push_bad;
  logic [2:0] code;

  // change counts once second and third stage agree
  assign lvl_n = (q.syn[1] == q.syn[2]) ? q.syn[2] : q.lvl;
  assign rise = lvl_n & ~q.lvl;
  assign push_bad = q.err_noise | q.err_bip | q.err_field |
                    (q.ph < SLOT_W);
  // status code priority [R08]
  assign code = programming ? swsbs_pkg::ST_PROGRAM :
                over_temp ? swsbs_pkg::ST_THERMAL :
                fault_no_bemf ? swsbs_pkg::ST_NO_BEMF :
                swsbs_pkg::ST_NORMAL;

  always_comb begin
    d = q;
    if (ce) begin
      d.latch_pulse = 1'b0;
      d.syn = {q.syn[1:0], bus.wire_lvl};
      d.lvl = lvl_n;
      if (!q.lvl) begin
        if (q.low_cnt != KILL_C) begin
          d.low_cnt = q.low_cnt + 20'h1;
        end
      end else begin
        d.low_cnt = '0;
      end
      d.ph = (q.ph == SLOT_M1) ? 16'h0 : q.ph + 16'h1;
      case (q.st)
        swsbs_pkg::D_IDLE: begin
          d.drive_low = 1'b0;
        end
        swsbs_pkg::D_START: begin
          // bit slot 0 begins right after the third low slot
          d.drive_low = 1'b0;
          d.st = swsbs_pkg::D_PUSH;
        end
        swsbs_pkg::D_PUSH: begin
          d.drive_low = 1'b0;
          if (q.ph == Q1) begin
            d.smp_a = q.lvl;
          end
          if (q.ph == Q3) begin
            d.smp_b = q.lvl;
          end
          if (q.ph == Q5) begin
            d.smp_c = q.lvl;
          end
          if (q.ph == Q7) begin
            if (q.smp_a != q.smp_b || q.smp_c != q.lvl) begin
              d.err_noise = 1'b1; // [R12]
            end
            if (q.smp_a == q.smp_c) begin
              d.err_bip = 1'b1; // [R16]
            end
            d.sh = {q.smp_a, q.sh[7:1]}; // [R02] [R03]
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == LAST_BIT) begin
              d.st = swsbs_pkg::D_SYNC;
              d.ph = '0;
            end
          end
        end
        swsbs_pkg::D_SYNC: begin
          d.drive_low = 1'b0;
          d.ph = q.ph + 16'h1;
          if (q.ph == SLOT_W && q.lvl) begin
            d.err_field = 1'b1; // [R19]
          end
          if (rise) begin
            d.st = swsbs_pkg::D_IDLE;
            if (q.sh[7:5] == my_address) begin // [R18]
              d.st = swsbs_pkg::D_PULL;
              d.ph = '0;
              d.bit_n = '0;
              if (push_bad) begin
                d.stat = swsbs_pkg::ST_SEL_FAIL; // [R19]
                d.eof_en = 1'b0;
              end else begin
                d.cmd = q.sh[4:0]; // [R04] [R05] [R06]
                d.off = 1'b0;
                d.latch_pulse = 1'b1;
                d.stat = code; // [R08]
                d.eof_en = 1'b1;
              end
            end
          end else if (q.ph == SYNC_TMO) begin
            d.st = swsbs_pkg::D_IDLE;
          end
        end
        swsbs_pkg::D_PULL: begin
          // first half carries the bit value, second its complement
          d.drive_low = (q.ph < HALF) ? ~q.stat[2] : q.stat[2]; // [R07]
          if (q.ph == SLOT_M1) begin
            d.stat = {q.stat[1:0], 1'b0};
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == LAST_STAT) begin
              d.st = swsbs_pkg::D_EOF;
              d.bit_n = '0;
            end
          end
        end
        swsbs_pkg::D_EOF: begin
          d.drive_low = q.eof_en && (q.ph < HALF); // [R10]
          if (q.ph == SLOT_M1) begin
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == LAST_EOF) begin
              d.st = swsbs_pkg::D_IDLE;
            end
          end
        end
        default: begin
          d.st = swsbs_pkg::D_IDLE;
        end
      endcase
      if (!q.lvl && q.low_cnt == START_C - 20'h1) begin
        d.st = swsbs_pkg::D_START; // [R01]
        d.ph = '0;
        d.bit_n = '0;
        d.drive_low = 1'b0;
        d.err_noise = 1'b0;
        d.err_bip = 1'b0;
        d.err_field = 1'b0;
      end
      if (!q.lvl && q.low_cnt == KILL_C - 20'h1) begin
        d.off = 1'b1; // [R17]
        d.cmd = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.syn <= 3'h7;
      q.lvl <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.dev_out = 1'b0;
  assign bus.dev_oe_n = ~q.drive_low;
  assign bridge_one_inhibit = q.cmd[swsbs_pkg::CMD_BR1_INH];
  assign bridge_one_direction = q.cmd[swsbs_pkg::CMD_BR1_DIR];
  assign energize = q.cmd[swsbs_pkg::CMD_ENERGIZE];
  assign bridge_two_direction = q.cmd[swsbs_pkg::CMD_BR2_DIR];
  assign bridge_two_inhibit = q.cmd[swsbs_pkg::CMD_BR2_INH];
  assign outputs_disabled = q.off;
  assign frame_latched = q.latch_pulse;
  assign rx_noise_error = q.err_noise;
  assign rx_biphase_error = q.err_bip;
  assign rx_field_error = q.err_field;
endmodule // swsbs_dev

// ===== swsbs_pkg.sv
package swsbs_pkg;
  // oscillator and slot timing
  localparam int OSC_KHZ = 640;
  localparam int OSC_PER_SLOT = 16;
  localparam int CLK_MHZ = 200;
  localparam int SLOT_NS = OSC_PER_SLOT * 1000000 / OSC_KHZ;
  localparam int SLOT_CYC = SLOT_NS * CLK_MHZ / 1000;
  // frame layout in slots and bits
  localparam int START_SLOTS = 3;
  localparam int KILL_SLOTS = 9;
  localparam int HOST_KILL_SLOTS = 10;
  localparam int PUSH_BITS = 8;
  localparam int STAT_BITS = 3;
  localparam int EOF_SLOTS = 4;
  // command bit positions
  localparam int CMD_BR1_INH = 0;
  localparam int CMD_BR1_DIR = 1;
  localparam int CMD_ENERGIZE = 2;
  localparam int CMD_BR2_DIR = 3;
  localparam int CMD_BR2_INH = 4;
  // status codes
  localparam logic [2:0] ST_NEVER = 3'h0;
  localparam logic [2:0] ST_NO_BEMF = 3'h2;
  localparam logic [2:0] ST_NORMAL = 3'h4;
  localparam logic [2:0] ST_THERMAL = 3'h5;
  localparam logic [2:0] ST_PROGRAM = 3'h6;
  localparam logic [2:0] ST_SEL_FAIL = 3'h7;
  typedef enum logic [2:0] {
    D_IDLE, D_START, D_PUSH, D_SYNC, D_PULL, D_EOF
  } swsbs_dev_st_t;
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_PUSH, H_SYNC, H_PULL, H_EOF, H_KILL
  } swsbs_host_st_t;
endpackage

// ===== swsbs_link_if.sv
`timescale 1ns/1ps
interface swsbs_link_if;
  logic dev_out;
  logic dev_oe_n;
  logic host_out;
  logic host_oe_n;
  logic wire_lvl;
  // open wire with pull-up: released drivers read as high
  assign wire_lvl = (dev_oe_n | dev_out) & (host_oe_n | host_out);
  modport dev (input wire_lvl, output dev_out, output dev_oe_n);
  modport host (input wire_lvl, output host_out, output host_oe_n);
endinterface

// ===== swsbs_host.sv
`timescale 1ns/1ps
module swsbs_host #(
  parameter int SLOT_CYC = swsbs_pkg::SLOT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  swsbs_link_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [4:0] cmd_control,
  input wire logic [2:0] cmd_address,
  input wire logic disable_req,
  output logic done,
  output logic frame_ok,
  output logic comm_failed,
  output logic rx_error,
  output logic status_bit_high,
  output logic status_bit_mid,
  output logic status_bit_low
);
  localparam logic [15:0] SLOT_M1 = 16'(SLOT_CYC - 1);
  localparam logic [15:0] HALF_M1 = 16'(SLOT_CYC / 2 - 1);
  localparam logic [15:0] QTR = 16'(SLOT_CYC / 4);
  localparam logic [15:0] QTR3 = 16'(3 * SLOT_CYC / 4);
  localparam logic [3:0] LAST_START = 4'(swsbs_pkg::START_SLOTS - 1);
  localparam logic [3:0] LAST_BIT = 4'(swsbs_pkg::PUSH_BITS - 1);
  localparam logic [3:0] LAST_STAT = 4'(swsbs_pkg::STAT_BITS - 1);
  localparam logic [3:0] LAST_EOF = 4'(swsbs_pkg::EOF_SLOTS - 1);
  localparam logic [3:0] LAST_KILL =
    4'(swsbs_pkg::HOST_KILL_SLOTS - 1);

  typedef struct packed {
    logic [2:0] syn;
    logic lvl;
    swsbs_pkg::swsbs_host_st_t st;
    logic [15:0] ph;
    logic [3:0] bit_n;
    logic [7:0] sh;
    logic drive_low;
    logic smp;
    logic [2:0] stat_rx;
    logic bad;
    logic eof_seen;
    logic done;
    logic ok;
    logic fail;
    logic [2:0] status;
  } swsbs_host_state_t;

  swsbs_host_state_t q;
  swsbs_host_state_t d;
  logic slot_end;
  logic eof_now;

  assign slot_end = (q.ph == SLOT_M1);
  assign eof_now = q.eof_seen | ~q.lvl;

  always_comb begin
    d = q;
    if (ce) begin
      d.done = 1'b0;
      d.syn = {q.syn[1:0], bus.wire_lvl};
      d.lvl = (q.syn[1] == q.syn[2]) ? q.syn[2] : q.lvl;
      d.ph = slot_end ? 16'h0 : q.ph + 16'h1;
      case (q.st)
        swsbs_pkg::H_IDLE: begin
          d.ph = '0;
          d.bit_n = '0;
          if (disable_req) begin
            d.st = swsbs_pkg::H_KILL; // [R17]
            d.drive_low = 1'b1;
          end else if (cmd_valid) begin
            d.st = swsbs_pkg::H_START; // [R01]
            d.sh = {cmd_address, cmd_control}; // [R03]
            d.drive_low = 1'b1;
          end
        end
        swsbs_pkg::H_START: begin
          if (slot_end) begin
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == LAST_START) begin
              d.st = swsbs_pkg::H_PUSH;
              d.bit_n = '0;
              d.drive_low = ~q.sh[0];
            end
          end
        end
        swsbs_pkg::H_PUSH: begin
          if (q.ph == HALF_M1) begin
            d.drive_low = q.sh[0];
          end
          if (slot_end) begin
            d.sh = {1'b0, q.sh[7:1]}; // [R02]
            d.bit_n = q.bit_n + 4'h1;
            d.drive_low = ~q.sh[1];
            if (q.bit_n == LAST_BIT) begin
              d.st = swsbs_pkg::H_SYNC; // [R05]
              d.drive_low = 1'b1;
            end
          end
        end
        swsbs_pkg::H_SYNC: begin
          if (slot_end) begin
            d.st = swsbs_pkg::H_PULL; // [R07]
            d.drive_low = 1'b0;
            d.bit_n = '0;
            d.bad = 1'b0;
          end
        end
        swsbs_pkg::H_PULL: begin
          if (q.ph == QTR) begin
            d.smp = q.lvl;
          end
          if (q.ph == QTR3) begin
            d.stat_rx = {q.stat_rx[1:0], q.smp};
            if (q.smp == q.lvl) begin
              d.bad = 1'b1;
            end
          end
          if (slot_end) begin
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == LAST_STAT) begin
              d.st = swsbs_pkg::H_EOF;
              d.bit_n = '0;
              d.eof_seen = 1'b0;
            end
          end
        end
        swsbs_pkg::H_EOF: begin
          // skip the tail of the last status bit still in the filter
          if (q.bit_n != 4'h0 || q.ph >= QTR) begin
            d.eof_seen = eof_now;
          end
          if (slot_end) begin
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == LAST_EOF) begin
              d.st = swsbs_pkg::H_IDLE;
              d.done = 1'b1;
              d.status = q.stat_rx;
              d.ok = eof_now && !q.bad && // [R09]
                     q.stat_rx != swsbs_pkg::ST_SEL_FAIL &&
                     q.stat_rx != swsbs_pkg::ST_NEVER;
              d.fail = !eof_now && // [R11]
                       q.stat_rx == swsbs_pkg::ST_SEL_FAIL;
            end
          end
        end
        swsbs_pkg::H_KILL: begin
          if (slot_end) begin
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == LAST_KILL) begin
              d.st = swsbs_pkg::H_IDLE;
              d.drive_low = 1'b0;
            end
          end
        end
        default: begin
          d.st = swsbs_pkg::H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.syn <= 3'h7;
      q.lvl <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready = ce && (q.st == swsbs_pkg::H_IDLE) && !disable_req;
  assign bus.host_out = 1'b0;
  assign bus.host_oe_n = ~q.drive_low;
  assign done = q.done;
  assign frame_ok = q.ok;
  assign comm_failed = q.fail;
  assign rx_error = q.bad;
  assign status_bit_high = q.status[2];
  assign status_bit_mid = q.status[1];
  assign status_bit_low = q.status[0];
endmodule // swsbs_host

// ===== swsbs_link_properties.sv
`timescale 1ns/1ps
module swsbs_link_properties #(
  parameter int SLOT_CYC = swsbs_pkg::SLOT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic host_out,
  input wire logic host_oe_n
);
  localparam int HALF = SLOT_CYC / 2;
  int h_lo_q;
  int h_hi_q;
  int d_lo_q;
  // run lengths of low drive and of host release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      h_lo_q <= 0;
      h_hi_q <= 0;
      d_lo_q <= 0;
    end else begin
      h_lo_q <= host_oe_n ? 0 : h_lo_q + 1;
      h_hi_q <= !host_oe_n ? 0 : (h_hi_q < 100000 ? h_hi_q + 1 : h_hi_q);
      d_lo_q <= dev_oe_n ? 0 : d_lo_q + 1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_drive_low_only: assert property (!dev_out && !host_out)
    else $error("wire driven high");
  a_no_contention: assert property (!dev_oe_n |-> host_oe_n)
    else $error("both ends drive the wire");
  a_slot_run_len: assert property ($rose(host_oe_n)
    |-> h_lo_q % HALF == 0)
    else $error("host low run not whole half slots");
  a_start_distinct: assert property ($rose(host_oe_n)
    |-> (h_lo_q <= 3 * HALF || h_lo_q >= 3 * SLOT_CYC))
    else $error("host low run ambiguous with start");
  a_kill_bound: assert property (h_lo_q <= 10 * SLOT_CYC)
    else $error("host low run too long");
  a_dev_run_half: assert property ($rose(dev_oe_n)
    |-> d_lo_q % HALF == 0)
    else $error("device low run not whole half slots");
  a_dev_run_max: assert property (d_lo_q <= SLOT_CYC)
    else $error("device low run too long");
  a_dev_window: assert property ($fell(dev_oe_n)
    |-> (h_hi_q > 0 && h_hi_q < 7 * SLOT_CYC))
    else $error("device drives outside its reply window");
  c_start: cover property ($rose(host_oe_n) && h_lo_q == 3 * SLOT_CYC);
  c_kill: cover property ($rose(host_oe_n) && h_lo_q >= 9 * SLOT_CYC);
  c_reply: cover property ($fell(dev_oe_n));
endmodule // swsbs_link_properties

// ===== single_wire_stepper_bus_slave_test.sv
`timescale 1ns/1ps
module single_wire_stepper_bus_slave_test;
  localparam int SC = 40;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  logic disable_req = 1'b0;
  logic [4:0] cmd_control = 5'h00;
  logic [2:0] cmd_address = 3'h0;
  logic [2:0] my_address = 3'h5;
  logic fault_no_bemf = 1'b0, over_temp = 1'b0, programming = 1'b0;
  wire cmd_ready, done, frame_ok, comm_failed, rx_error, st_h, st_m, st_l;
  wire [4:0] br;
  wire dis, latched, e_noise, e_bip, e_fld;
  int fail_count = 0, compares = 0, latch_cnt = 0, cyc = 0;
  swsbs_link_if lnk ();
  always #2.5 mclk = ~mclk;
  swsbs_host #(.SLOT_CYC(SC)) swsbs_host_i (.mclk(mclk), .rstn(rstn),
    .ce(ce), .bus(lnk.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_control(cmd_control), .cmd_address(cmd_address),
    .disable_req(disable_req), .done(done), .frame_ok(frame_ok),
    .comm_failed(comm_failed), .rx_error(rx_error),
    .status_bit_high(st_h), .status_bit_mid(st_m), .status_bit_low(st_l));
  swsbs_dev #(.SLOT_CYC(SC)) swsbs_dev_i (.mclk(mclk), .rstn(rstn),
    .ce(ce), .bus(lnk.dev), .my_address(my_address),
    .fault_no_bemf(fault_no_bemf), .over_temp(over_temp),
    .programming(programming), .bridge_one_inhibit(br[0]),
    .bridge_one_direction(br[1]), .energize(br[2]),
    .bridge_two_direction(br[3]), .bridge_two_inhibit(br[4]),
    .outputs_disabled(dis), .frame_latched(latched),
    .rx_noise_error(e_noise), .rx_biphase_error(e_bip),
    .rx_field_error(e_fld));
  swsbs_link_properties #(.SLOT_CYC(SC)) swsbs_link_properties_i (
    .mclk(mclk), .rstn(rstn), .dev_out(lnk.dev_out),
    .dev_oe_n(lnk.dev_oe_n), .host_out(lnk.host_out),
    .host_oe_n(lnk.host_oe_n));

  task automatic close_out();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (latched === 1'b1) latch_cnt++;
    if (cyc == 10000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one host frame; wire levels taken mid first half of each bit slot
  task automatic send(input logic [4:0] ctl, input logic [2:0] adr);
    logic [7:0] got;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_control <= ctl;
    cmd_address <= adr;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      repeat (k == 0 ? 3 * SC + SC / 4 : SC) @(posedge mclk);
      got[k] = lnk.wire_lvl;
    end
    chk(got, {adr, ctl});
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    chk({7'h00, done}, 8'h01);
  endtask

  task automatic expect_frame(input logic [4:0] ctl, input logic [2:0] code);
    chk({5'h00, st_h, st_m, st_l}, {5'h00, code});
    chk({5'h00, frame_ok, comm_failed, rx_error},
      {5'h00, code != 3'h7, code == 3'h7, code == 3'h7});
    chk({3'h0, br}, {3'h0, ctl});
  endtask

  task automatic t_normal();
    int l0;
    l0 = latch_cnt;
    send(5'h15, 3'h5);
    expect_frame(5'h15, swsbs_pkg::ST_NORMAL);
    chk(8'(latch_cnt - l0), 8'h01);
    chk({4'h0, dis, e_noise, e_bip, e_fld}, 8'h00);
  endtask

  task automatic t_status();
    logic [2:0] codes [3];
    codes = '{swsbs_pkg::ST_PROGRAM, swsbs_pkg::ST_THERMAL,
      swsbs_pkg::ST_NO_BEMF};
    for (int k = 0; k < 3; k++) begin
      programming <= (k == 0);
      over_temp <= (k == 1);
      fault_no_bemf <= (k == 2);
      send(5'(k * 7 + 3), 3'h5);
      expect_frame(5'(k * 7 + 3), codes[k]);
    end
    fault_no_bemf <= 1'b0;
  endtask

  task automatic t_other_addr();
    int l0;
    l0 = latch_cnt;
    send(5'h1F, 3'h2);
    expect_frame(5'h11, swsbs_pkg::ST_SEL_FAIL);
    chk(8'(latch_cnt - l0), 8'h00);
  endtask

  task automatic t_kill();
    int n;
    n = 0;
    disable_req <= 1'b1;
    while (lnk.host_oe_n !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    disable_req <= 1'b0;
    repeat (11 * SC) @(posedge mclk);
    chk({2'h0, dis, br}, 8'h20);
    t_normal();
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({br, dis, latched, e_fld}, 8'h00);
    t_normal();
    t_status();
    t_other_addr();
    t_kill();
    close_out();
  end
endmodule // single_wire_stepper_bus_slave_test
